// ===== core/asrc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

module asrc_ctrl
   import asrc_pkg::*;
(
   input  wire logic              core_clk,
   input  wire logic              arst_n,
   input  wire logic              req_valid,
   output logic                   req_ready,
   input  wire asrc_req_t         req,
   output logic                   rd_valid,
   output logic      [DATA_W-1:0] rd_data,
   output logic                   chip_sel_n,
   output logic                   out_en_n,
   output logic                   wr_strobe_n,
   output logic      [ADDR_W-1:0] word_address,
   output logic      [DATA_W-1:0] data_line_out,
   output logic      [DATA_W-1:0] data_line_oe,
   input  wire logic [DATA_W-1:0] data_line_in
);

   ////////////////////////////////////////////////////////////////////////
   // Reset release

   logic       rst_meta;                    // First reset stage
   logic       rst_n;                       // Released reset copy

   // Async assert, clocked release
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Data line input synchroniser

   logic [DATA_W-1:0] data_sync;            // Read data, two flops late

   asrc_sync u_sync (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .d        (data_line_in),
      .q        (data_sync)
   );

   ////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      asrc_state_t       st;                // Sequencer state
      logic [2:0]        cnt;               // Cycles left in phase
      asrc_pins_t        pins;              // Registered pin levels
      logic              rd_valid;          // Read result strobe
      logic [DATA_W-1:0] rd_data;           // Captured read word
   } asrc_ctrl_t;

   // Pins that leave the memory deselected and idle
   localparam asrc_pins_t PINS_IDLE = '{
      chip_sel_n:    1'b1,
      out_en_n:      1'b1,
      wr_strobe_n:   1'b1,
      word_address:  18'h00000,
      data_line_out: 4'h0,
      data_line_oe:  4'h0
   };

   asrc_ctrl_t s;                           // Current state
   asrc_ctrl_t next_s;                      // Next state

   // Ready only when idle and out of reset: while the internal reset
   // still holds the sequencer, a request seen as taken would be lost,
   // so ready stays low until the released copy is high
   assign req_ready = (s.st == ASRC_IDLE) && rst_n;

   ////////////////////////////////////////////////////////////////////////
   // Phase lengths at counter width

   // Read waits one more cycle for the synchroniser to settle
   localparam logic [2:0] RD_LEN  = 3'(RD_CYC + 1);
   // Strobe low cycles; one 20 ns cycle covers the pulse width
   localparam logic [2:0] WR_LEN  = 3'(WR_CYC);
   // Turnaround cycles before the next select
   localparam logic [2:0] REC_LEN = 3'(REC_CYC);

   ////////////////////////////////////////////////////////////////////////
   // Phase counter helpers

   // Last cycle of a timed phase; counts are never loaded with zero,
   // so the sequencer cannot stall waiting for a wrap
   function automatic logic asrc_last(input logic [2:0] cnt);
      return (cnt == CNT_ONE);
   endfunction : asrc_last

   // One cycle fewer left in the phase
   function automatic logic [2:0] asrc_dec(input logic [2:0] cnt);
      return cnt - CNT_ONE;
   endfunction : asrc_dec

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic

   always_comb begin
      next_s          = s;
      next_s.rd_valid = 1'b0;
      case (s.st)
         ASRC_IDLE: begin
            // Deselected, data lines floating
            next_s.pins = PINS_IDLE;
            next_s.pins.word_address = s.pins.word_address;
            if (req_valid) begin
               // Address set with select in the same edge
               next_s.pins.word_address = req.addr;
               next_s.pins.chip_sel_n   = 1'b0;
               if (req.write) begin
                  // Both low starts the write; OE kept high
                  next_s.pins.wr_strobe_n   = 1'b0;
                  next_s.pins.data_line_out = req.wdata;
                  next_s.pins.data_line_oe  = 4'hF;
                  next_s.cnt = WR_LEN;
                  next_s.st  = ASRC_WRITE;
               end else begin
                  // Strobe stays high, device drives data
                  next_s.pins.out_en_n = 1'b0;
                  next_s.cnt = RD_LEN;
                  next_s.st  = ASRC_READ;
               end
            end
         end
         ASRC_READ: begin
            // Wait access plus synchroniser delay
            if (asrc_last(s.cnt)) begin
               next_s.rd_valid = 1'b1;
               next_s.rd_data  = data_sync;
               // Release select and OE; memory floats
               next_s.pins.chip_sel_n = 1'b1;
               next_s.pins.out_en_n   = 1'b1;
               next_s.cnt = REC_LEN;
               next_s.st  = ASRC_REC;
            end else begin
               // Data not yet through both stages
               next_s.cnt = asrc_dec(s.cnt);
            end
         end
         ASRC_WRITE: begin
            // Overlap of select and strobe is the write
            if (asrc_last(s.cnt)) begin
               // Strobe rises first: strobe-terminated write
               next_s.pins.wr_strobe_n = 1'b1;
               next_s.st = ASRC_HOLD;
            end else begin
               next_s.cnt = asrc_dec(s.cnt);
            end
         end
         ASRC_HOLD: begin
            // Data and address held one cycle past strobe rise
            next_s.pins.chip_sel_n   = 1'b1;
            next_s.pins.data_line_oe = 4'h0;
            next_s.cnt = REC_LEN;
            next_s.st  = ASRC_REC;
         end
         ASRC_REC: begin
            // Turnaround so no bus fight with lingering drivers
            if (asrc_last(s.cnt)) begin
               // Back to idle; ready rises with the state
               next_s.st = ASRC_IDLE;
            end else begin
               next_s.cnt = asrc_dec(s.cnt);
            end
         end
         default: begin
            // Unused codes recover to a safe deselected idle
            next_s.st   = ASRC_IDLE;
            next_s.pins = PINS_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s.st       <= ASRC_IDLE;
         s.cnt      <= 3'h0;
         s.pins     <= PINS_IDLE;
         s.rd_valid <= 1'b0;
         s.rd_data  <= 4'h0;
      end else begin
         s <= next_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs, all from flops

   assign chip_sel_n    = s.pins.chip_sel_n;
   assign out_en_n      = s.pins.out_en_n;
   assign wr_strobe_n   = s.pins.wr_strobe_n;
   assign word_address  = s.pins.word_address;
   assign data_line_out = s.pins.data_line_out;
   assign data_line_oe  = s.pins.data_line_oe;
   assign rd_valid      = s.rd_valid;
   assign rd_data       = s.rd_data;

endmodule : asrc_ctrl

`default_nettype wire

// ===== common/asrc_pkg.sv
package asrc_pkg;

   // Memory geometry
   localparam int ADDR_W = 18;             // Word address width
   localparam int DATA_W = 4;              // Word width
   localparam int WORDS  = 262144;         // Words in the array

   // Core clock period in ns
   localparam int CLK_NS = 20;

   // Read timing, ns as printed
   localparam int T_RC_NS  = 15;           // Read cycle time
   localparam int T_ACE_NS = 15;           // Select to data valid
   localparam int T_HZ_NS  = 7;            // Select high to high Z

   // Write timing, ns as printed
   localparam int T_WC_NS  = 15;           // Write cycle time
   localparam int T_PWE_NS = 12;           // Strobe pulse width
   localparam int T_SD_NS  = 8;            // Data setup to write end
   localparam int T_HD_NS  = 0;            // Data hold from write end

   // Ceiling division, least times round up, none under one cycle
   function automatic int asrc_cyc(input int ns);
      int c;
      c = (ns + CLK_NS - 1) / CLK_NS;
      return (c < 1) ? 1 : c;
   endfunction : asrc_cyc

   localparam int RD_CYC  = asrc_cyc(T_ACE_NS) + 1; // Plus one for sampling
   localparam int WR_CYC  = asrc_cyc(T_PWE_NS);
   localparam int REC_CYC = asrc_cyc(T_HZ_NS);      // Bus turnaround

   localparam logic [2:0] CNT_ONE = 3'h1;

   // Controller states
   typedef enum logic [2:0] {
      ASRC_IDLE  = 3'b000,
      ASRC_READ  = 3'b001,
      ASRC_WRITE = 3'b010,
      ASRC_HOLD  = 3'b011,
      ASRC_REC   = 3'b100
   } asrc_state_t;

   // Pins toward the memory
   typedef struct packed {
      logic              chip_sel_n;
      logic              out_en_n;
      logic              wr_strobe_n;
      logic [ADDR_W-1:0] word_address;
      logic [DATA_W-1:0] data_line_out;
      logic [DATA_W-1:0] data_line_oe;
   } asrc_pins_t;

   // User request
   typedef struct packed {
      logic              write;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } asrc_req_t;

endpackage : asrc_pkg

// ===== core/asrc_sync.sv
`timescale 1ns/1ps
`default_nettype none

// Two-flop synchroniser for the data lines read back from the memory
module asrc_sync
   import asrc_pkg::*;
(
   input  wire logic              core_clk,
   input  wire logic              rst_n,
   input  wire logic [DATA_W-1:0] d,
   output logic      [DATA_W-1:0] q
);

   logic [DATA_W-1:0] meta;                 // First stage, read by q only

   // Two stages, only the second looks at the first
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta <= 4'h0;
         q    <= 4'h0;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end

endmodule : asrc_sync

`default_nettype wire

// ===== sim/asrc_mem.sv
`timescale 1ns/1ps
`default_nettype none
// Behavioural memory array on the far side of the controller
module asrc_mem
   import asrc_pkg::*;
(
   input  wire logic              chip_sel_n,
   input  wire logic              out_en_n,
   input  wire logic              wr_strobe_n,
   input  wire logic [ADDR_W-1:0] word_address,
   input  wire logic [DATA_W-1:0] data_line,
   output logic      [DATA_W-1:0] dq
);
   logic [DATA_W-1:0] mem [WORDS];        // Full array
   logic [DATA_W-1:0] last = 4'h0;        // Last driven word
   wire  logic        rd   = !chip_sel_n && !out_en_n && wr_strobe_n;
   // Store on the first rise of select or strobe
   always @(posedge wr_strobe_n or posedge chip_sel_n) begin
      if (!chip_sel_n || !wr_strobe_n)
         mem[word_address] = data_line;
   end
   // Drive when read, else float as the inverse, not a held value
   always @* begin
      if (rd) begin
         dq   = mem[word_address];
         last = dq;
      end else
         dq = ~last;
   end
endmodule : asrc_mem
`default_nettype wire

// ===== sim/asrc_ctrl_chk.sv
`timescale 1ns/1ps
`default_nettype none
// Protocol checker on the controller's ports
module asrc_ctrl_chk
   import asrc_pkg::*;
(
   input  wire logic              core_clk,
   input  wire logic              arst_n,
   input  wire logic              req_valid,
   input  wire logic              req_ready,
   input  wire asrc_req_t         req,
   input  wire logic              rd_valid,
   input  wire logic [DATA_W-1:0] rd_data,
   input  wire logic              chip_sel_n,
   input  wire logic              out_en_n,
   input  wire logic              wr_strobe_n,
   input  wire logic [ADDR_W-1:0] word_address,
   input  wire logic [DATA_W-1:0] data_line_out,
   input  wire logic [DATA_W-1:0] data_line_oe,
   input  wire logic [DATA_W-1:0] data_line_in
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   // Taken requests by kind
   wire logic tk_rd = req_valid && req_ready && !req.write;
   wire logic tk_wr = req_valid && req_ready && req.write;
   property p_rd_we;    !out_en_n |-> wr_strobe_n; endproperty
   property p_rd_go;    tk_rd |=> !chip_sel_n && !out_en_n
      && word_address == $past(req.addr); endproperty
   property p_rd_ans;   tk_rd |-> ##[4:5] rd_valid; endproperty
   property p_rd_pulse; rd_valid |=> !rd_valid; endproperty
   property p_wr_go;    tk_wr |=> !chip_sel_n && !wr_strobe_n
      && data_line_oe == 4'hF && data_line_out == $past(req.wdata);
   endproperty
   property p_wr_len;   $fell(wr_strobe_n) |-> !chip_sel_n ##1
      wr_strobe_n ##1 chip_sel_n; endproperty
   property p_wr_hold;  $rose(wr_strobe_n) |-> data_line_oe == 4'hF
      && $stable(data_line_out) && $stable(word_address); endproperty
   property p_float;    chip_sel_n |-> data_line_oe == 4'h0; endproperty
   property p_idle;     req_ready |-> chip_sel_n && wr_strobe_n;
   endproperty
   property p_rst_rdy;  $rose(arst_n) |-> !req_ready && chip_sel_n
      && data_line_oe == 4'h0 ##1 !req_ready; endproperty
   a_rd_we:    assert property (p_rd_we)    else $error("strobe in read");
   a_rd_go:    assert property (p_rd_go)    else $error("read start");
   a_rd_ans:   assert property (p_rd_ans)   else $error("read answer");
   a_rd_pulse: assert property (p_rd_pulse) else $error("valid width");
   a_wr_go:    assert property (p_wr_go)    else $error("write start");
   a_wr_len:   assert property (p_wr_len)   else $error("write end");
   a_wr_hold:  assert property (p_wr_hold)  else $error("write hold");
   a_float:    assert property (p_float)    else $error("bus driven");
   a_idle:     assert property (p_idle)     else $error("idle pins");
   a_rst_rdy:  assert property (p_rst_rdy) else $error("early ready");
   c_rd:  cover property (tk_rd);
   c_wr:  cover property (tk_wr);
   c_ans: cover property (rd_valid);
endmodule : asrc_ctrl_chk
bind asrc_ctrl asrc_ctrl_chk chk (.core_clk(core_clk), .arst_n(arst_n),
   .req_valid(req_valid), .req_ready(req_ready), .req(req),
   .rd_valid(rd_valid), .rd_data(rd_data), .chip_sel_n(chip_sel_n),
   .out_en_n(out_en_n), .wr_strobe_n(wr_strobe_n),
   .word_address(word_address), .data_line_out(data_line_out),
   .data_line_oe(data_line_oe), .data_line_in(data_line_in));
`default_nettype wire

// ===== sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import asrc_pkg::*;
   logic              core_clk  = 1'b0;
   logic              arst_n    = 1'b0;
   logic              req_valid = 1'b0;
   asrc_req_t         req       = '0;
   logic              req_ready, rd_valid, chip_sel_n, out_en_n, wr_strobe_n;
   logic [DATA_W-1:0] rd_data, data_line_out, data_line_oe, dq;
   logic [ADDR_W-1:0] word_address;
   int                miscompares = 0;
   int                comparisons = 0;
   // Bus level: controller where enabled, memory model elsewhere
   wire  logic [DATA_W-1:0] data_line_in =
      (data_line_oe & data_line_out) | (~data_line_oe & dq);
   asrc_ctrl dut (.core_clk(core_clk), .arst_n(arst_n),
      .req_valid(req_valid), .req_ready(req_ready), .req(req),
      .rd_valid(rd_valid), .rd_data(rd_data), .chip_sel_n(chip_sel_n),
      .out_en_n(out_en_n), .wr_strobe_n(wr_strobe_n),
      .word_address(word_address), .data_line_out(data_line_out),
      .data_line_oe(data_line_oe), .data_line_in(data_line_in));
   asrc_mem mem (.chip_sel_n(chip_sel_n), .out_en_n(out_en_n),
      .wr_strobe_n(wr_strobe_n), .word_address(word_address),
      .data_line(data_line_in), .dq(dq));
   initial begin
      forever #10 core_clk = ~core_clk;
   end
   ////////////////////////////////////////////////////////////////////
   task automatic final_report();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : final_report
   task automatic chk(input string what, input logic [3:0] exp, got);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // Inputs always move 1 ns after the rising edge
   task automatic tick();
      @(posedge core_clk);
      #1;
   endtask : tick
   task automatic hang(input string what);
      miscompares++;
      $display("mismatch %s expected 1 seen timeout", what);
      final_report();
   endtask : hang
   // Hold the request until it is taken at an edge with ready high
   task automatic send(input logic wr, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d);
      int n;
      n   = 0;
      req = '{write: wr, addr: a, wdata: d};
      req_valid = 1'b1;
      while (req_ready !== 1'b1) begin
         tick();
         n++;
         if (n > 20) hang("req_ready");
      end
      tick();
      req_valid = 1'b0;
   endtask : send
   // Write, then follow strobe and select phase by phase
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [3:0] d);
      send(1'b1, a, d);
      chk("cs_we", 4'h0, {2'b00, chip_sel_n, wr_strobe_n});
      chk("wdata", d, data_line_out);
      tick();
      chk("cs_we", 4'h1, {2'b00, chip_sel_n, wr_strobe_n});
      chk("wdata", d, data_line_out);
      tick();
      chk("oe", 4'h0, data_line_oe);
   endtask : wr
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [3:0] e);
      int n;
      send(1'b0, a, 4'h0);
      chk("rd_pins", 4'h1, {1'b0, out_en_n, chip_sel_n, wr_strobe_n});
      for (n = 0; rd_valid !== 1'b1; n++) begin
         if (n > 10) hang("rd_valid");
         tick();
      end
      chk("rd_data", e, rd_data);
   endtask : rd
   ////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      repeat (4) tick();
      chk("idle_pins", 4'h7, {1'b0, chip_sel_n, out_en_n, wr_strobe_n});
      chk("oe", 4'h0, data_line_oe);
      arst_n = 1'b1;
      $display("test reset done");
   endtask : t_reset
   // Extreme and alternating addresses keep every address bit busy
   task automatic t_table();
      logic [ADDR_W-1:0] a [4] = '{18'h00000, 18'h3FFFF, 18'h15555, 18'h2AAAA};
      logic [3:0]        d [4] = '{4'h1, 4'hF, 4'hA, 4'h5};
      for (int i = 0; i < 4; i++)
         wr(a[i], d[i]);
      for (int i = 0; i < 4; i++)
         rd(a[i], d[i]);
      $display("test table done");
   endtask : t_table
   task automatic t_overwrite();
      wr(18'h00001, 4'h6);
      wr(18'h00001, 4'h9);
      rd(18'h00001, 4'h9);
      rd(18'h00001, 4'h9);
      rd(18'h00000, 4'h1);
      $display("test overwrite done");
   endtask : t_overwrite
   // Reset mid-run: pins idle, no ready until released, array still read
   task automatic t_midreset();
      arst_n = 1'b0;
      tick();
      chk("idle_pins", 4'h7, {1'b0, chip_sel_n, out_en_n, wr_strobe_n});
      chk("ready", 4'h0, {3'b000, req_ready});
      arst_n = 1'b1;
      rd(18'h15555, 4'hA);
      $display("test midreset done");
   endtask : t_midreset
   initial begin
      t_reset();
      t_table();
      t_overwrite();
      t_midreset();
      final_report();
   end
endmodule : testbench
`default_nettype wire
